// *** hdl/sgfs_params.svh ***
// Purpose: Register indices, reset values and field widths of the gate and field sequencer
// Assumes: Byte address of a register is four times its index
// Notes: Definitions only
`ifndef SGFS_PARAMS_SVH
`define SGFS_PARAMS_SVH

// Register indices (byte address = index * 4)
`define SGFS_IDX_GATE_SEL 8'h1C
`define SGFS_IDX_FIELD_CNT 8'h2A
`define SGFS_IDX_ORDER_LO 8'h2B
`define SGFS_IDX_ORDER_HI 8'h2C
`define SGFS_IDX_FIELD_PTR 8'h30
`define SGFS_IDX_FIELD_MASK 8'h31
`define SGFS_IDX_FIELD_LINE1 8'h32
`define SGFS_IDX_FIELD_LINE2 8'h33
`define SGFS_IDX_PAIR_SEL 8'h34
`define SGFS_IDX_UPD_CTRL 8'h35
`define SGFS_IDX_STATUS 8'h36

// Reset values
`define SGFS_RST_GATE_SEL 24'h000000
`define SGFS_RST_FIELD_CNT 3'h1
`define SGFS_RST_ORDER_LO 25'h0000000
`define SGFS_RST_ORDER_HI 10'h000
`define SGFS_RST_MASK 24'h000000
`define SGFS_RST_PAIR_SEL 24'h000000
`define SGFS_LINE_MAX 13'h1FFF

// Field layout
`define SGFS_FSEL_W 5
`define SGFS_ORDER_LEN 7
`define SGFS_ORDER_LO_LEN 5
`define SGFS_HRESP_OKAY 1'h0

`endif

// *** hdl/sgfs_pkg.sv ***
// Purpose: Shared types of the gate and field sequencer
// Assumes: Constants live in sgfs_params.svh
// Notes: Types only
package sgfs_pkg;
  typedef logic [4:0] sgfs_fsel_t;
  typedef logic [12:0] sgfs_line_t;
  typedef logic [23:0] sgfs_vout_t;
  typedef enum logic {SGFS_UPD_SCK, SGFS_UPD_VD} sgfs_upd_t;
endpackage : sgfs_pkg

// *** hdl/sgfs_field_if.sv ***
// Purpose: Link between the register side and the field sequencer
// Assumes: Single clock domain
// Notes: ctl drives the program, seq returns position and field
`timescale 1ns/1ps
interface sgfs_field_if;
  import sgfs_pkg::*;
  logic ce;
  logic vd_fall;
  logic restart;
  logic [2:0] count;
  sgfs_fsel_t order [7];
  logic [2:0] pos;
  sgfs_fsel_t field_cur;
  sgfs_fsel_t field_nxt;
  logic start_pend;
  modport seq (input ce, vd_fall, restart, count, order,
               output pos, field_cur, field_nxt, start_pend);
  modport ctl (output ce, vd_fall, restart, count, order,
               input pos, field_cur, field_nxt, start_pend);
endinterface : sgfs_field_if

// *** hdl/sgfs_field_seq.sv ***
// Purpose: Steps through the programmed field list on each vertical sync fall
// Assumes: vd_fall is a one-cycle pulse
// Notes: A restart takes effect at the next vertical sync fall
`timescale 1ns/1ps
module sgfs_field_seq
  import sgfs_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Sequencer link
  sgfs_field_if.seq f
);
  logic [2:0] pos_r;
  logic [2:0] pos_adv;
  logic [2:0] pos_nxt;
  sgfs_fsel_t field_r;
  logic start_pend_r;

  // Next position: wrap after the last counted field, count 0 holds entry 0
  always_comb begin
    pos_adv = (pos_r + 3'h1 >= f.count) ? 3'h0 : pos_r + 3'h1; // RULE13
    pos_nxt = start_pend_r ? 3'h0 : pos_adv; // RULE12
  end

  assign f.field_nxt = f.order[pos_nxt];
  assign f.pos = pos_r;
  assign f.field_cur = field_r;
  assign f.start_pend = start_pend_r;

  // Position and field advance together at the field boundary
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_r <= 3'h0;
      field_r <= '0;
    end else if (f.ce && f.vd_fall) begin
      pos_r <= pos_nxt; // RULE19
      field_r <= f.order[pos_nxt]; // RULE17
    end
  end

  // Restart request; a set in the boundary cycle wins so new order is used
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_pend_r <= 1'b1;
    end else if (f.ce) begin
      if (f.restart) begin
        start_pend_r <= 1'b1; // RULE14
      end else if (f.vd_fall) begin
        start_pend_r <= 1'b0;
      end
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence last_field_s;
    f.ce && f.vd_fall && !start_pend_r && (pos_r + 3'h1 >= f.count);
  endsequence

  seq_wrap_a: assert property (last_field_s |=> pos_r == 3'h0) // RULE13
    else $error("field position did not wrap");
  seq_restart_a: assert property ( // RULE12
    f.ce && f.vd_fall && start_pend_r |=> pos_r == 3'h0 && field_r == $past(f.order[0]))
    else $error("restart did not begin at first entry");
endmodule : sgfs_field_seq

// *** hdl/sgfs_gate_gen.sv ***
// Purpose: Builds gate waveforms from start polarity and a selected toggle pair
// Assumes: Toggle hit inputs pulse for one cycle at each toggle position
// Notes: Output is combinational; the top registers it
`timescale 1ns/1ps
module sgfs_gate_gen
  import sgfs_pkg::*;
#(
  parameter int N = 24
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Line timing
  input wire logic line_start,
  input wire logic gate_line,
  // Pattern inputs
  input wire logic [N-1:0] start_pol,
  input wire logic [N-1:0] tog_one,
  input wire logic [N-1:0] tog_two,
  input wire logic [N-1:0] tog_three,
  input wire logic [N-1:0] tog_four,
  // Per-output controls
  input wire logic [N-1:0] pair_sel,
  input wire logic [N-1:0] mask,
  // Gate waveform
  output logic [N-1:0] wave
);
  logic [N-1:0] between_r;
  logic [N-1:0] first_hit;
  logic [N-1:0] second_hit;

  // Only two of the four toggles reach a gate output
  assign first_hit = (~pair_sel & tog_one) | (pair_sel & tog_three); // RULE4
  assign second_hit = (~pair_sel & tog_two) | (pair_sel & tog_four); // RULE3

  // Pulse window opens at the first toggle and closes at the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      between_r <= '0;
    end else if (ce) begin
      if (line_start) begin
        between_r <= '0;
      end else begin
        between_r <= (between_r | first_hit) & ~second_hit; // RULE3
      end
    end
  end

  // Masked outputs and lines off the gate line sit at start polarity
  assign wave = start_pol ^ (between_r & {N{gate_line}} & ~mask); // RULE18

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  toggle_pair_a: assert property ( // RULE4
    ce && !line_start && !pair_sel[0] && tog_one[0] && !tog_two[0] |=> between_r[0])
    else $error("first toggle of pair did not open pulse");
endmodule : sgfs_gate_gen

// *** hdl/sgfs_top.sv ***
// Purpose: Sensor gate assignment and field sequencing with an AHB-Lite register file
// Assumes: All timing inputs are synchronous to hclk; one-cycle line_start pulses
// Notes: Reads take one wait state, writes none
// Functional notes
// [RULE1] Twenty-four vertical outputs, each usable as transfer pulse or gate pulse.
// [RULE2] Gate select register at 0x1C, one bit per output, 1 means gate.
// [RULE3] Gate waveform uses start polarity and only two of four toggles.
// [RULE4] Per-output pair select: 0 uses toggles one and two, 1 three and four.
// [RULE5] Per-field mask suppresses each gate output whose bit is high.
// [RULE6] Per-field 13-bit line number chooses the gate line in the field.
// [RULE7] Second line number repeats gate pulses; host sets it equal or maximum.
// [RULE8] First gate line marks where substrate clocking starts each field.
// [RULE9] Host must program gate select to 0xFF8000.
// [RULE10] Field count register at 0x2A, valid values one to seven.
// [RULE11] Registers 0x2B and 0x2C hold the ordered field list.
// [RULE12] Start on first list entry, advance one entry per vertical sync.
// [RULE13] Wrap to first entry after the counted fields, cycling forever.
// [RULE14] Only a write to 0x2C resets the position counter.
// [RULE15] Host should write all three mode registers in one field.
// [RULE16] Mode registers update at once, or at second sync fall if deferred.
// [RULE17] Each list entry is five bits naming a stored field.
// [RULE18] Masked gate output holds its start polarity for the whole field.
// [RULE19] Position advances and field parameters latch at the sync fall.
`timescale 1ns/1ps
`include "sgfs_params.svh"
module sgfs_top
  import sgfs_pkg::*;
#(
  parameter int NUM_FIELDS = 32
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Field and line timing
  input wire logic vertical_sync,
  input wire logic line_start,
  // Vertical pattern generator
  input wire logic [23:0] vertical_transfer_pulse,
  input wire logic [23:0] pattern_start_pol,
  input wire logic [23:0] toggle_position_one,
  input wire logic [23:0] toggle_position_two,
  input wire logic [23:0] toggle_position_three,
  input wire logic [23:0] toggle_position_four,
  // Outputs to driver and substrate clock logic
  output logic [23:0] vertical_out,
  output logic substrate_clock_start,
  output logic [4:0] active_field
);
  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  sgfs_field_if fif ();
  logic acc;
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] wr_idx_r;
  logic [7:0] rd_idx_r;
  logic wr_en;
  logic wr_mode;
  logic hreadyout_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_word;
  sgfs_vout_t gate_sel_r;
  sgfs_vout_t pair_sel_r;
  logic [2:0] cnt_sh_r;
  logic [24:0] ord_lo_sh_r;
  logic [9:0] ord_hi_sh_r;
  logic [2:0] cnt_act_r;
  logic [24:0] ord_lo_act_r;
  logic [9:0] ord_hi_act_r;
  sgfs_upd_t upd_mode_r;
  logic vd_pend_r;
  logic hi_pend_r;
  logic apply;
  sgfs_fsel_t field_ptr_r;
  sgfs_vout_t mem_mask [NUM_FIELDS];
  sgfs_line_t mem_line1 [NUM_FIELDS];
  sgfs_line_t mem_line2 [NUM_FIELDS];
  sgfs_vout_t field_mask_r;
  sgfs_line_t line1_r;
  sgfs_line_t line2_r;
  sgfs_line_t line_r;
  logic vd_d_r;
  logic vd_fall;
  logic on_line1;
  logic on_line1_d_r;
  logic gate_line;
  sgfs_vout_t wave;
  sgfs_vout_t vertical_out_r;
  logic substrate_clock_r;

  // Mode registers share the deferred-update path
  function automatic logic is_mode_idx(input logic [7:0] idx);
    return (idx == `SGFS_IDX_FIELD_CNT) || (idx == `SGFS_IDX_ORDER_LO) ||
           (idx == `SGFS_IDX_ORDER_HI);
  endfunction : is_mode_idx

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave: writes land in the data phase, reads wait one cycle so that a
  // write just before them is already visible
  assign acc = hsel && htrans[1] && hready;
  assign wr_en = ce && wr_pend_r;
  assign wr_mode = wr_en && is_mode_idx(wr_idx_r);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
      rd_idx_r <= 8'h00;
      hreadyout_r <= 1'b1;
    end else if (ce) begin
      wr_pend_r <= acc && hwrite;
      rd_pend_r <= acc && !hwrite;
      hreadyout_r <= !(acc && !hwrite);
      if (acc) begin
        wr_idx_r <= haddr[9:2];
        rd_idx_r <= haddr[9:2];
      end
    end
  end

  // Read multiplexer; unmapped words read zero
  always_comb begin
    rd_word = 32'h00000000;
    unique case (rd_idx_r)
      `SGFS_IDX_GATE_SEL: rd_word = {8'h00, gate_sel_r};
      `SGFS_IDX_FIELD_CNT: rd_word = {29'h00000000, cnt_sh_r};
      `SGFS_IDX_ORDER_LO: rd_word = {7'h00, ord_lo_sh_r};
      `SGFS_IDX_ORDER_HI: rd_word = {22'h000000, ord_hi_sh_r};
      `SGFS_IDX_FIELD_PTR: rd_word = {27'h0000000, field_ptr_r};
      `SGFS_IDX_FIELD_MASK: rd_word = {8'h00, mem_mask[field_ptr_r]};
      `SGFS_IDX_FIELD_LINE1: rd_word = {19'h00000, mem_line1[field_ptr_r]};
      `SGFS_IDX_FIELD_LINE2: rd_word = {19'h00000, mem_line2[field_ptr_r]};
      `SGFS_IDX_PAIR_SEL: rd_word = {8'h00, pair_sel_r};
      `SGFS_IDX_UPD_CTRL: rd_word = {31'h00000000, upd_mode_r == SGFS_UPD_VD};
      `SGFS_IDX_STATUS: rd_word = {20'h00000, vd_pend_r, fif.start_pend, 2'h0,
                                   fif.pos, fif.field_cur};
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
    end else if (ce && rd_pend_r) begin
      hrdata_r <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software-visible control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_sel_r <= `SGFS_RST_GATE_SEL;
      pair_sel_r <= `SGFS_RST_PAIR_SEL;
      field_ptr_r <= '0;
      upd_mode_r <= SGFS_UPD_SCK;
      cnt_sh_r <= `SGFS_RST_FIELD_CNT;
      ord_lo_sh_r <= `SGFS_RST_ORDER_LO;
      ord_hi_sh_r <= `SGFS_RST_ORDER_HI;
    end else if (wr_en) begin
      unique case (wr_idx_r)
        `SGFS_IDX_GATE_SEL: gate_sel_r <= hwdata[23:0]; // RULE2
        `SGFS_IDX_PAIR_SEL: pair_sel_r <= hwdata[23:0]; // RULE4
        `SGFS_IDX_FIELD_PTR: field_ptr_r <= hwdata[4:0];
        `SGFS_IDX_UPD_CTRL: upd_mode_r <= hwdata[0] ? SGFS_UPD_VD : SGFS_UPD_SCK;
        `SGFS_IDX_FIELD_CNT: cnt_sh_r <= hwdata[2:0]; // RULE10
        `SGFS_IDX_ORDER_LO: ord_lo_sh_r <= hwdata[24:0]; // RULE11
        `SGFS_IDX_ORDER_HI: ord_hi_sh_r <= hwdata[9:0]; // RULE11
        default: ;
      endcase
    end
  end

  // Stored field definitions, picked per field by the sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_FIELDS; i++) begin
        mem_mask[i] <= `SGFS_RST_MASK;
        mem_line1[i] <= `SGFS_LINE_MAX;
        mem_line2[i] <= `SGFS_LINE_MAX;
      end
    end else if (wr_en) begin
      unique case (wr_idx_r)
        `SGFS_IDX_FIELD_MASK: mem_mask[field_ptr_r] <= hwdata[23:0]; // RULE5
        `SGFS_IDX_FIELD_LINE1: mem_line1[field_ptr_r] <= hwdata[12:0]; // RULE6
        `SGFS_IDX_FIELD_LINE2: mem_line2[field_ptr_r] <= hwdata[12:0]; // RULE7
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode register update: immediate, or deferred so that the copy is taken at
  // the first sync fall and enters use at the second
  assign apply = vd_pend_r && vd_fall && !wr_mode;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_act_r <= `SGFS_RST_FIELD_CNT;
      ord_lo_act_r <= `SGFS_RST_ORDER_LO;
      ord_hi_act_r <= `SGFS_RST_ORDER_HI;
    end else if (ce) begin
      if (wr_mode && upd_mode_r == SGFS_UPD_SCK) begin
        unique case (wr_idx_r)
          `SGFS_IDX_FIELD_CNT: cnt_act_r <= hwdata[2:0];
          `SGFS_IDX_ORDER_LO: ord_lo_act_r <= hwdata[24:0];
          `SGFS_IDX_ORDER_HI: ord_hi_act_r <= hwdata[9:0];
          default: ;
        endcase
      end else if (apply) begin
        cnt_act_r <= cnt_sh_r; // RULE16
        ord_lo_act_r <= ord_lo_sh_r;
        ord_hi_act_r <= ord_hi_sh_r;
      end
    end
  end

  // Deferred-update flags; a write in the fall cycle keeps them set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vd_pend_r <= 1'b0;
      hi_pend_r <= 1'b0;
    end else if (ce) begin
      if (wr_mode && upd_mode_r == SGFS_UPD_VD) begin
        vd_pend_r <= 1'b1; // RULE16
        if (wr_idx_r == `SGFS_IDX_ORDER_HI) begin
          hi_pend_r <= 1'b1;
        end
      end else if (apply) begin
        vd_pend_r <= 1'b0;
        hi_pend_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Field sequencer link; only the high order word restarts the position
  assign fif.ce = ce;
  assign fif.vd_fall = vd_fall;
  assign fif.count = cnt_act_r;
  assign fif.restart = (wr_en && wr_idx_r == `SGFS_IDX_ORDER_HI && // RULE14
                        upd_mode_r == SGFS_UPD_SCK) || (apply && hi_pend_r);

  // First entry sits in the low bits of the low order word
  for (genvar k = 0; k < `SGFS_ORDER_LEN; k++) begin : g_order
    if (k < `SGFS_ORDER_LO_LEN) begin : g_lo
      assign fif.order[k] = ord_lo_act_r[k*`SGFS_FSEL_W +: `SGFS_FSEL_W]; // RULE17
    end else begin : g_hi
      assign fif.order[k] = ord_hi_act_r[(k-5)*`SGFS_FSEL_W +: `SGFS_FSEL_W];
    end
  end

  sgfs_field_seq u_seq (
    .hclk(hclk),
    .hresetn(hresetn),
    .f(fif.seq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Field boundary and line counting
  assign vd_fall = vd_d_r && !vertical_sync;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vd_d_r <= 1'b0;
      line_r <= '0;
    end else if (ce) begin
      vd_d_r <= vertical_sync;
      if (vd_fall) begin
        line_r <= '0;
      end else if (line_start && line_r != `SGFS_LINE_MAX) begin
        line_r <= line_r + 13'h0001;
      end
    end
  end

  // Field parameters latch at the same boundary the position advances on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      field_mask_r <= `SGFS_RST_MASK;
      line1_r <= `SGFS_LINE_MAX;
      line2_r <= `SGFS_LINE_MAX;
    end else if (ce && vd_fall) begin
      field_mask_r <= mem_mask[fif.field_nxt]; // RULE19
      line1_r <= mem_line1[fif.field_nxt];
      line2_r <= mem_line2[fif.field_nxt];
    end
  end

  // Gate line is either programmed line; equal values simply overlap
  assign on_line1 = line_r == line1_r;
  assign gate_line = on_line1 || line_r == line2_r; // RULE7

  sgfs_gate_gen #(.N(24)) u_gate (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .line_start(line_start),
    .gate_line(gate_line),
    .start_pol(pattern_start_pol),
    .tog_one(toggle_position_one),
    .tog_two(toggle_position_two),
    .tog_three(toggle_position_three),
    .tog_four(toggle_position_four),
    .pair_sel(pair_sel_r),
    .mask(field_mask_r),
    .wave(wave)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Output stage: per-output choice of transfer pulse or gate waveform
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vertical_out_r <= '0;
      on_line1_d_r <= 1'b0;
      substrate_clock_r <= 1'b0;
    end else if (ce) begin
      vertical_out_r <= (gate_sel_r & wave) | (~gate_sel_r & vertical_transfer_pulse); // RULE1
      on_line1_d_r <= on_line1;
      substrate_clock_r <= on_line1 && !on_line1_d_r; // RULE8
    end
  end

  assign vertical_out = vertical_out_r;
  assign substrate_clock_start = substrate_clock_r;
  assign active_field = fif.field_cur;
  assign hreadyout = hreadyout_r;
  assign hresp = `SGFS_HRESP_OKAY;
  assign hrdata = hrdata_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence deferred_write_s;
    ce && wr_mode && upd_mode_r == SGFS_UPD_VD && !vd_fall;
  endsequence

  sequence first_fall_s;
    ce && vd_pend_r && vd_fall && !wr_mode;
  endsequence

  gate_sel_wr_a: assert property ( // RULE2
    wr_en && wr_idx_r == `SGFS_IDX_GATE_SEL |=> gate_sel_r == $past(hwdata[23:0]))
    else $error("gate select write not stored");
  xfer_pass_a: assert property (ce |=> // RULE1
    ((vertical_out_r ^ $past(vertical_transfer_pulse)) & ~$past(gate_sel_r)) == 24'h000000)
    else $error("transfer output not passed through");
  masked_hold_a: assert property (ce |=> // RULE18
    ((vertical_out_r ^ $past(pattern_start_pol)) & $past(gate_sel_r & field_mask_r)) == '0)
    else $error("masked gate output left start polarity");
  off_line_a: assert property (ce && !gate_line |=> // RULE6
    ((vertical_out_r ^ $past(pattern_start_pol)) & $past(gate_sel_r)) == 24'h000000)
    else $error("gate output toggled off the gate line");
  mode_keep_a: assert property ( // RULE14
    wr_en && !fif.start_pend && !vd_fall && wr_idx_r != `SGFS_IDX_ORDER_HI
    |=> !fif.start_pend)
    else $error("position reset by a write other than high order word");
  hi_restart_a: assert property ( // RULE14
    wr_en && wr_idx_r == `SGFS_IDX_ORDER_HI && upd_mode_r == SGFS_UPD_SCK |=> fif.start_pend)
    else $error("high order write did not restart position");
  vd_defer_a: assert property (deferred_write_s |=> $stable(cnt_act_r) && // RULE16
    $stable(ord_lo_act_r) && $stable(ord_hi_act_r))
    else $error("deferred mode write applied early");
  vd_apply_a: assert property (first_fall_s |=> cnt_act_r == $past(cnt_sh_r) && // RULE16
    ord_hi_act_r == $past(ord_hi_sh_r) && !vd_pend_r)
    else $error("deferred mode write not copied at sync fall");
  substrate_clock_ref_a: assert property (ce && on_line1 && !on_line1_d_r |=> substrate_clock_r) // RULE8
    else $error("substrate start missed the first gate line");
  field_latch_a: assert property (ce && vd_fall |=> // RULE19
    line1_r == $past(mem_line1[fif.field_nxt]) && active_field == $past(fif.field_nxt))
    else $error("field parameters not latched at sync fall");
endmodule : sgfs_top

// *** bench/sgfs_timing_model.sv ***
// Purpose: Field and line timing source on the sensor side of the block
// Assumes: Driven just after hclk rising edges
// Notes: Sync idles high; a field begins at its fall
`timescale 1ns/1ps
module sgfs_timing_model (
  // Clock
  hclk,
  // Timing to the block
  vertical_sync,
  line_start
);
  input wire logic hclk;
  output logic vertical_sync;
  output logic line_start;
  // Idle levels from time zero
  initial begin
    vertical_sync = 1'b1;
    line_start = 1'b0;
  end
  // Fall, then two edges so the new field is visible before return
  task automatic field_edge();
    @(posedge hclk);
    vertical_sync <= 1'b0;
    repeat (2) @(posedge hclk);
    vertical_sync <= 1'b1;
  endtask : field_edge
  // One-cycle line pulse
  task automatic line_pulse();
    @(posedge hclk);
    line_start <= 1'b1;
    @(posedge hclk);
    line_start <= 1'b0;
  endtask : line_pulse
endmodule : sgfs_timing_model

// *** bench/sgfs_top_bench.sv ***
// Purpose: Self-checking bench of the gate and field sequencer
// Assumes: ce held high so no bus transfer is lost
// Notes: Masters one AHB-Lite transfer at a time
`timescale 1ns/1ps
module sgfs_top_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [23:0] vtp = 24'h0;
  logic [23:0] sp = 24'h0;
  logic [3:0][23:0] tg = '0;
  logic hreadyout, hresp, vs, ls, scs;
  logic [31:0] hrdata;
  logic [23:0] vo;
  logic [4:0] af;
  logic sub_seen = 1'b0;
  int fail_count = 0;
  int n_tests = 0;
  sgfs_timing_model tm (.hclk(hclk), .vertical_sync(vs), .line_start(ls));
  sgfs_top dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .vertical_sync(vs),
    .line_start(ls), .vertical_transfer_pulse(vtp), .pattern_start_pol(sp),
    .toggle_position_one(tg[0]), .toggle_position_two(tg[1]),
    .toggle_position_three(tg[2]), .toggle_position_four(tg[3]),
    .vertical_out(vo), .substrate_clock_start(scs), .active_field(af));
  // Clock, 100 ns period
  initial forever #50 hclk = ~hclk;
  // Remember any substrate start pulse, it lasts one cycle only
  always @(posedge hclk) if (scs === 1'b1) sub_seen <= 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  // Address phase held until hready, then data phase until hready
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic chk(input logic [31:0] a, e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp(q, e);
  endtask : chk
  // Pulse the toggles named in k for one cycle, then let the output settle
  task automatic tog(input logic [3:0] k);
    @(posedge hclk);
    for (int i = 0; i < 4; i++) tg[i] <= {24{k[i]}};
    @(posedge hclk);
    tg <= '0;
    repeat (2) @(posedge hclk);
  endtask : tog
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    chk(32'h70, 32'h0);
    chk(32'hA8, 32'h1);
    chk(32'hC8, 32'h1FFF);
    cmp(hresp, 1'b0);
    wr(32'h70, 32'hFF8000);
    chk(32'h70, 32'hFF8000);
    wr(32'h300, 32'h5);
    chk(32'h300, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_gate();
    wr(32'hC0, 32'h0);
    wr(32'hC8, 32'h2);
    wr(32'hCC, 32'h1FFF);
    wr(32'hC4, 32'h0);
    wr(32'hD0, 32'h0);
    tm.field_edge();
    vtp <= 24'hFF5A5A;
    tm.line_pulse();
    cmp(vo, 24'h005A5A);
    cmp(sub_seen, 1'b0);
    tm.line_pulse();
    tog(4'b0001);
    cmp(vo[23:15], 9'h1FF);
    cmp(sub_seen, 1'b1);
    tog(4'b0010);
    cmp(vo[23:15], 9'h000);
    // Next field: output 23 on the upper pair, output 22 masked and starting high
    wr(32'hC4, 32'h400000);
    wr(32'hD0, 32'h800000);
    wr(32'hCC, 32'h3);
    sp <= 24'h400000;
    tm.field_edge();
    tm.line_pulse();
    tm.line_pulse();
    tog(4'b0001);
    cmp(vo[23:15], 9'h0FF);
    tog(4'b0100);
    cmp(vo[23:15], 9'h1FF);
    tm.line_pulse();
    tog(4'b0001);
    cmp(vo[23:15], 9'h0FF);
    $display("test gate done");
  endtask : t_gate
  task automatic t_seq();
    wr(32'hA8, 32'h3);
    wr(32'hAC, 32'h4525);
    wr(32'hB0, 32'h0);
    tm.field_edge();
    cmp(af, 5'd5);
    tm.field_edge();
    cmp(af, 5'd9);
    wr(32'hA8, 32'h3);
    tm.field_edge();
    cmp(af, 5'd17);
    tm.field_edge();
    cmp(af, 5'd5);
    wr(32'hB0, 32'h0);
    tm.field_edge();
    cmp(af, 5'd5);
    $display("test sequence done");
  endtask : t_seq
  task automatic t_seven();
    wr(32'hA8, 32'h7);
    wr(32'hAC, 32'h520C41);
    wr(32'hB0, 32'hE6);
    for (int i = 0; i < 8; i++) begin
      tm.field_edge();
      cmp(af, 5'((i % 7) + 1));
    end
    $display("test seven done");
  endtask : t_seven
  // Deferred count: old count still steps the first fall, new one wraps at the second
  task automatic t_defer();
    wr(32'hD4, 32'h1);
    wr(32'hA8, 32'h1);
    chk(32'hD8, 32'h801);
    tm.field_edge();
    cmp(af, 5'd2);
    tm.field_edge();
    cmp(af, 5'd1);
    $display("test defer done");
  endtask : t_defer
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  // Main sequence, reset held for four cycles
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_gate();
    t_seq();
    t_seven();
    t_defer();
    conclude();
  end
  // Watchdog, ample over the fewer than two hundred cycles the tests take
  initial begin
    #400000;
    fail_count++;
    conclude();
  end
endmodule : sgfs_top_bench
